// ---- lsb_alu.sv ----
`timescale 1ns/1ps
// What this block does
// - Compare subtracts, sets flags, keeps destination
// - Negate writes zero minus destination
// - Sign widen copies low part sign upward
// - Zero widen clears upper part
// - AND destination with source or immediate
// - OR destination with source or immediate
// - XOR destination with source or immediate
// - NOT inverts destination at width
// - Arithmetic shift; right keeps sign bit
// - Logical shift fills vacated bit with zero
// - Rotate feeds leaving bit to other end
// - Rotate through carry flag
// - Set one byte bit, immediate or register index
// - Clear one selected byte bit
// - Invert one selected byte bit
// - Zero flag gets inverted bit, operand kept
// - Carry ANDed with selected bit
// - Carry ANDed with inverted bit, immediate index
// - Carry ORed with selected bit
// - Carry ORed with inverted bit, immediate index
module lsb_alu
(
    input  wire logic                 i_clock,      // System clock
    input  wire logic                 i_rst,        // Async reset, high
    input  wire logic                 i_valid,      // Operation request
    input  wire lsb_pkg::lsb_op_t     i_op,         // Operation code
    input  wire logic [1:0]           i_size,       // Operand width
    input  wire logic [31:0]          i_dest,       // Destination operand
    input  wire logic [31:0]          i_source,     // Source register value
    input  wire logic [31:0]          i_imm,        // Immediate value
    input  wire logic                 i_use_imm,    // Select immediate source
    input  wire logic [2:0]           i_bit_imm,    // 3-bit bit index
    input  wire logic                 i_bit_by_reg, // Index from register
    input  wire logic [3:0]           i_flags,      // Current N Z V C
    output logic                      o_done,       // Result valid pulse
    output logic [31:0]               o_result,     // Result value
    output logic                      o_write,      // Destination write
    output logic [3:0]                o_flags,      // New N Z V C
    output logic                      o_illegal     // Bad request pulse
);

    // ****************************************************************
    // Combinational datapath
    // ****************************************************************
    logic [31:0] src_val;
    logic [31:0] msk;
    logic [31:0] sgn;
    logic [32:0] diff;
    logic [31:0] res;
    logic        wr;
    logic        carry_n;
    logic        over_n;
    logic        z_over;
    logic        use_nz;
    logic        bad;
    logic [2:0]  bit_idx;
    logic        sel_bit;
    logic [7:0]  bit_one;
    logic        neg_w;
    logic        zero_w;
    logic [31:0] sl;
    logic [31:0] sr;
    logic        out_l;
    logic        out_r;

    assign src_val = i_use_imm ? i_imm : i_source;
    assign bit_idx = i_bit_by_reg ? i_source[2:0] : i_bit_imm;
    assign sel_bit = i_dest[bit_idx];
    assign bit_one = 8'h01 << bit_idx;

    // Width mask and sign position
    always_comb
    begin
        msk = 32'hffff_ffff;
        sgn = 32'h8000_0000;
        if (i_size == lsb_pkg::SIZE_BYTE)
        begin
            msk = 32'h0000_00ff;
            sgn = 32'h0000_0080;
        end
        else if (i_size == lsb_pkg::SIZE_WORD)
        begin
            msk = 32'h0000_ffff;
            sgn = 32'h0000_8000;
        end
    end

    // Shift helpers and outgoing bits
    assign sl    = (i_dest << 1) & msk;
    assign sr    = (i_dest & msk) >> 1;
    assign out_l = |(i_dest & sgn);
    assign out_r = i_dest[0];

    // Main operation select
    always_comb
    begin
        res     = i_dest;
        wr      = 1'b1;
        use_nz  = 1'b1;
        bad     = 1'b0;
        carry_n = i_flags[lsb_pkg::FLAG_C];
        over_n  = 1'b0;
        z_over  = 1'b0;
        diff    = 33'h0;
        unique case (i_op)
            lsb_pkg::compare_op:
            begin
                diff    = {1'b0, i_dest & msk} - {1'b0, src_val & msk};
                res     = diff[31:0] & msk;
                wr      = 1'b0;
                carry_n = |(diff[32:0] & {1'b0, msk << 1 | 32'h1} & ~{1'b0, msk});
                if (i_size == lsb_pkg::SIZE_LONG)
                    carry_n = diff[32];
                over_n  = |((i_dest ^ src_val) & (i_dest ^ diff[31:0]) & sgn);
            end
            lsb_pkg::negate_op:
            begin
                res    = (32'h0000_0000 - i_dest) & msk;
                over_n = (i_dest & msk) == sgn;
                carry_n = |(i_dest & msk);
            end
            lsb_pkg::sign_widen_op:
            begin
                if (i_size == lsb_pkg::SIZE_WORD)
                    res = {16'h0000, {8{i_dest[7]}}, i_dest[7:0]};
                else
                    res = {{16{i_dest[15]}}, i_dest[15:0]};
                bad = (i_size == lsb_pkg::SIZE_BYTE);
            end
            lsb_pkg::zero_widen_op:
            begin
                if (i_size == lsb_pkg::SIZE_WORD)
                    res = {24'h00_0000, i_dest[7:0]};
                else
                    res = {16'h0000, i_dest[15:0]};
                bad = (i_size == lsb_pkg::SIZE_BYTE);
            end
            lsb_pkg::and_op:  res = i_dest & src_val & msk;
            lsb_pkg::or_op:   res = (i_dest | src_val) & msk;
            lsb_pkg::xor_op:  res = (i_dest ^ src_val) & msk;
            lsb_pkg::not_op:  res = ~i_dest & msk;
            lsb_pkg::arith_left_shift_op:
            begin
                res     = sl;
                carry_n = out_l;
                over_n  = out_l ^ (|(sl & sgn));
            end
            lsb_pkg::arith_right_shift_op:
            begin
                res     = sr | (i_dest & sgn);
                carry_n = out_r;
            end
            lsb_pkg::logic_left_shift_op:
            begin
                res     = sl;
                carry_n = out_l;
            end
            lsb_pkg::logic_right_shift_op:
            begin
                res     = sr;
                carry_n = out_r;
            end
            lsb_pkg::rotate_left_op:
            begin
                res     = sl | {31'h0, out_l};
                carry_n = out_l;
            end
            lsb_pkg::rotate_right_op:
            begin
                res     = sr | (out_r ? sgn : 32'h0);
                carry_n = out_r;
            end
            lsb_pkg::carry_rotate_left_op:
            begin
                res     = sl | {31'h0, i_flags[lsb_pkg::FLAG_C]};
                carry_n = out_l;
            end
            lsb_pkg::carry_rotate_right_op:
            begin
                res     = sr | (i_flags[lsb_pkg::FLAG_C] ? sgn : 32'h0);
                carry_n = out_r;
            end
            lsb_pkg::bit_force_one_op:
            begin
                res    = {24'h0, i_dest[7:0] | bit_one};
                use_nz = 1'b0;
            end
            lsb_pkg::bit_force_zero_op:
            begin
                res    = {24'h0, i_dest[7:0] & ~bit_one};
                use_nz = 1'b0;
            end
            lsb_pkg::bit_flip_op:
            begin
                res    = {24'h0, i_dest[7:0] ^ bit_one};
                use_nz = 1'b0;
            end
            lsb_pkg::bit_probe_op:
            begin
                wr     = 1'b0;
                use_nz = 1'b0;
                z_over = 1'b1;
            end
            lsb_pkg::carry_bit_and_op:
            begin
                carry_n = i_flags[lsb_pkg::FLAG_C] & sel_bit;
                wr = 1'b0;
                use_nz = 1'b0;
            end
            lsb_pkg::carry_inv_bit_and_op:
            begin
                carry_n = i_flags[lsb_pkg::FLAG_C] & ~sel_bit;
                wr = 1'b0;
                use_nz = 1'b0;
                bad = i_bit_by_reg;
            end
            lsb_pkg::carry_bit_or_op:
            begin
                carry_n = i_flags[lsb_pkg::FLAG_C] | sel_bit;
                wr = 1'b0;
                use_nz = 1'b0;
            end
            lsb_pkg::carry_inv_bit_or_op:
            begin
                carry_n = i_flags[lsb_pkg::FLAG_C] | ~sel_bit;
                wr = 1'b0;
                use_nz = 1'b0;
                bad = i_bit_by_reg;
            end
            default: bad = 1'b1;
        endcase
    end

    // ****************************************************************
    // Flag evaluation
    // ****************************************************************
    lsb_flag_unit lsb_flag_unit_inst
    (
        .i_value    (res),
        .i_size     (i_size),
        .o_negative (neg_w),
        .o_zero     (zero_w)
    );

    // ****************************************************************
    // Output registers
    // ****************************************************************
    // Handshake outputs
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_done    <= 1'b0;
            o_write   <= 1'b0;
            o_illegal <= 1'b0;
        end
        else
        begin
            o_done    <= i_valid & ~bad;
            o_write   <= i_valid & ~bad & wr;
            o_illegal <= i_valid & bad;
        end
    end

    // Result and flags
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_result <= lsb_pkg::RESULT_RESET;
            o_flags  <= lsb_pkg::FLAGS_RESET;
        end
        else if (i_valid & ~bad)
        begin
            o_result <= res;
            o_flags[lsb_pkg::FLAG_C] <= carry_n;
            o_flags[lsb_pkg::FLAG_V] <= use_nz ? over_n : i_flags[lsb_pkg::FLAG_V];
            o_flags[lsb_pkg::FLAG_N] <= use_nz ? neg_w : i_flags[lsb_pkg::FLAG_N];
            o_flags[lsb_pkg::FLAG_Z] <= z_over ? ~sel_bit : (use_nz ? zero_w : i_flags[lsb_pkg::FLAG_Z]);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_compare_nowrite: assert property (@(posedge i_clock) disable iff (i_rst)
        i_valid && i_op == lsb_pkg::compare_op |=> o_done && !o_write)
        else $error("compare wrote destination");
    chk_negate_value: assert property (@(posedge i_clock) disable iff (i_rst)
        i_valid && i_op == lsb_pkg::negate_op |=> o_result == ((32'h0 - $past(i_dest)) & $past(msk)))
        else $error("negate result wrong");
    chk_sign_widen: assert property (@(posedge i_clock) disable iff (i_rst)
        i_valid && i_op == lsb_pkg::sign_widen_op && i_size == lsb_pkg::SIZE_LONG
        |=> o_result[31:16] == {16{$past(i_dest[15])}})
        else $error("sign widen wrong");
    chk_zero_widen: assert property (@(posedge i_clock) disable iff (i_rst)
        i_valid && i_op == lsb_pkg::zero_widen_op && i_size == lsb_pkg::SIZE_WORD
        |=> o_result == {24'h0, $past(i_dest[7:0])})
        else $error("zero widen wrong");
    chk_xor_value: assert property (@(posedge i_clock) disable iff (i_rst)
        i_valid && i_op == lsb_pkg::xor_op |=> o_result == ($past(i_dest ^ src_val) & $past(msk)))
        else $error("xor result wrong");
    chk_shr_sign: assert property (@(posedge i_clock) disable iff (i_rst)
        i_valid && i_op == lsb_pkg::arith_right_shift_op |=> |(o_result & $past(sgn)) == $past(out_l))
        else $error("sign bit lost");
    chk_rotc_carry: assert property (@(posedge i_clock) disable iff (i_rst)
        i_valid && i_op == lsb_pkg::carry_rotate_left_op
        |=> o_result[0] == $past(i_flags[0]) && o_flags[0] == $past(out_l))
        else $error("carry rotate wrong");
    chk_probe_zero: assert property (@(posedge i_clock) disable iff (i_rst)
        i_valid && i_op == lsb_pkg::bit_probe_op |=> o_flags[2] == !$past(sel_bit) && !o_write)
        else $error("bit probe wrong");
    chk_inv_and_imm: assert property (@(posedge i_clock) disable iff (i_rst)
        i_valid && i_op == lsb_pkg::carry_inv_bit_and_op && i_bit_by_reg |=> o_illegal && !o_done)
        else $error("register index accepted");
    chk_byte_zero: assert property (@(posedge i_clock) disable iff (i_rst)
        i_valid && i_op == lsb_pkg::not_op && i_size == lsb_pkg::SIZE_BYTE
        |=> o_flags[2] == (o_result[7:0] == 8'h00))
        else $error("zero flag wrong");

    cov_compare: cover property (@(posedge i_clock) i_valid && i_op == lsb_pkg::compare_op);
    cov_rotate:  cover property (@(posedge i_clock) i_valid && i_op == lsb_pkg::rotate_right_op);
    cov_bit_reg: cover property (@(posedge i_clock) i_valid && i_op == lsb_pkg::bit_flip_op && i_bit_by_reg);
    cov_illegal: cover property (@(posedge i_clock) o_illegal);

endmodule

// ---- lsb_pkg.sv ----
package lsb_pkg;

    // ****************************************************************
    // Operation codes
    // ****************************************************************
    typedef enum logic [4:0]
    {
        compare_op,
        negate_op,
        sign_widen_op,
        zero_widen_op,
        and_op,
        or_op,
        xor_op,
        not_op,
        arith_left_shift_op,
        arith_right_shift_op,
        logic_left_shift_op,
        logic_right_shift_op,
        rotate_left_op,
        rotate_right_op,
        carry_rotate_left_op,
        carry_rotate_right_op,
        bit_force_one_op,
        bit_force_zero_op,
        bit_flip_op,
        bit_probe_op,
        carry_bit_and_op,
        carry_inv_bit_and_op,
        carry_bit_or_op,
        carry_inv_bit_or_op
    } lsb_op_t;

    // ****************************************************************
    // Operand widths
    // ****************************************************************
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    // ****************************************************************
    // Flag positions in the condition flags
    // ****************************************************************
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;
    localparam int FLAG_W = 4;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [3:0]  FLAGS_RESET  = 4'h0;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam int          PIPE_DEPTH   = 1;

endpackage

// ---- lsb_flag_unit.sv ----
`timescale 1ns/1ps
// Flag evaluation at the operand width
module lsb_flag_unit
(
    input  wire logic [31:0] i_value,    // Result value
    input  wire logic [1:0]  i_size,     // Operand width
    output logic             o_negative, // Sign bit at width
    output logic             o_zero      // Result zero at width
);

    // ****************************************************************
    // Width-dependent sign and zero
    // ****************************************************************
    always_comb
    begin
        o_negative = i_value[31];
        o_zero     = (i_value == 32'h0000_0000);
        if (i_size == lsb_pkg::SIZE_BYTE)
        begin
            o_negative = i_value[7];
            o_zero     = (i_value[7:0] == 8'h00);
        end
        else if (i_size == lsb_pkg::SIZE_WORD)
        begin
            o_negative = i_value[15];
            o_zero     = (i_value[15:0] == 16'h0000);
        end
    end

endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;

    // ****************************************************************
    // Signals and counters
    // ****************************************************************
    localparam logic [1:0] SB = lsb_pkg::SIZE_BYTE;
    localparam logic [1:0] SW = lsb_pkg::SIZE_WORD;
    localparam logic [1:0] SL = lsb_pkg::SIZE_LONG;
    logic             i_clock;
    logic             i_rst;
    logic             i_valid;
    lsb_pkg::lsb_op_t i_op;
    logic [1:0]       i_size;
    logic [31:0]      i_dest;
    logic [31:0]      i_source;
    logic [31:0]      i_imm;
    logic             i_use_imm;
    logic [2:0]       i_bit_imm;
    logic             i_bit_by_reg;
    logic [3:0]       i_flags;
    logic             o_done;
    logic [31:0]      o_result;
    logic             o_write;
    logic [3:0]       o_flags;
    logic             o_illegal;
    logic [31:0]      prev_res;
    logic [3:0]       prev_flg;
    int               n_fail;
    int               compares;

    lsb_alu lsb_alu_inst
    (
        .i_clock      (i_clock),
        .i_rst        (i_rst),
        .i_valid      (i_valid),
        .i_op         (i_op),
        .i_size       (i_size),
        .i_dest       (i_dest),
        .i_source     (i_source),
        .i_imm        (i_imm),
        .i_use_imm    (i_use_imm),
        .i_bit_imm    (i_bit_imm),
        .i_bit_by_reg (i_bit_by_reg),
        .i_flags      (i_flags),
        .o_done       (o_done),
        .o_result     (o_result),
        .o_write      (o_write),
        .o_flags      (o_flags),
        .o_illegal    (o_illegal)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Drive one request at the falling edge, sample at the next one
    task automatic op(input lsb_pkg::lsb_op_t o, input logic [1:0] s, input logic [31:0] d, input logic [31:0] src,
                      input logic [31:0] im, input logic [2:0] bi, input logic br, input logic [3:0] f);
        prev_res = o_result;
        prev_flg = o_flags;
        i_valid = 1'b1;
        i_op = o;
        i_size = s;
        i_dest = d;
        i_source = src;
        i_imm = im;
        i_use_imm = (im != 32'h0);
        i_bit_imm = bi;
        i_bit_by_reg = br;
        i_flags = f;
        @(negedge i_clock);
    endtask

    // Accepted op: result only judged when written back
    task automatic want(input logic [31:0] r, input logic w, input logic [3:0] f, input logic [3:0] fm);
        compares++;
        if (o_done !== 1'b1 || o_illegal !== 1'b0 || o_write !== w || (w && o_result !== r)
            || (o_flags & fm) !== (f & fm))
        begin
            n_fail++;
            $display("[ERR] %0t op %0d res=%h flags=%h", $time, i_op, o_result, o_flags);
        end
    endtask

    // Refused op: pulse and outputs held
    task automatic bad();
        compares++;
        if (o_illegal !== 1'b1 || o_done !== 1'b0 || o_write !== 1'b0 || o_result !== prev_res
            || o_flags !== prev_flg)
        begin
            n_fail++;
            $display("[ERR] %0t refusal of op %0d not seen", $time, i_op);
        end
    endtask

    // Leave one idle cycle between tests
    task automatic fin(input string s);
        i_valid = 1'b0;
        @(negedge i_clock);
        $display("test %s done", s);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_compare();
        op(lsb_pkg::compare_op, SB, 32'h05, 32'h07, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0, 1'b0, 4'h9, 4'hf);
        op(lsb_pkg::compare_op, SW, 32'h1234, 32'h0, 32'h1234, 3'h0, 1'b0, 4'hf);
        want(32'h0, 1'b0, 4'h4, 4'hf);
        op(lsb_pkg::compare_op, SL, 32'h8000_0000, 32'h1, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0, 1'b0, 4'h2, 4'hf);
        fin("compare");
    endtask

    task automatic t_negate();
        op(lsb_pkg::negate_op, SB, 32'h1234_5601, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0000_00ff, 1'b1, 4'h9, 4'hf);
        op(lsb_pkg::negate_op, SW, 32'h0000_8000, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0000_8000, 1'b1, 4'hb, 4'hf);
        op(lsb_pkg::negate_op, SL, 32'h0, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0, 1'b1, 4'h4, 4'hf);
        fin("negate");
    endtask

    task automatic t_widen();
        op(lsb_pkg::sign_widen_op, SW, 32'h1234_ab80, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0000_ff80, 1'b1, 4'h8, 4'hc);
        op(lsb_pkg::sign_widen_op, SL, 32'habcd_7fff, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0000_7fff, 1'b1, 4'h0, 4'hc);
        op(lsb_pkg::zero_widen_op, SW, 32'h0000_ab80, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0000_0080, 1'b1, 4'h0, 4'hc);
        op(lsb_pkg::zero_widen_op, SL, 32'hffff_8000, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0000_8000, 1'b1, 4'h0, 4'hc);
        op(lsb_pkg::sign_widen_op, SB, 32'h0000_0080, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        bad();
        op(lsb_pkg::zero_widen_op, SB, 32'h0000_0080, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        bad();
        fin("widen");
    endtask

    task automatic t_logic();
        op(lsb_pkg::and_op, SW, 32'h1111_f0f0, 32'h0ff0, 32'h0, 3'h0, 1'b0, 4'h3);
        want(32'h0000_00f0, 1'b1, 4'h1, 4'hf);
        op(lsb_pkg::or_op, SL, 32'h8000_0000, 32'hffff, 32'h1, 3'h0, 1'b0, 4'h3);
        want(32'h8000_0001, 1'b1, 4'h9, 4'hf);
        op(lsb_pkg::xor_op, SB, 32'hf0, 32'h0, 32'hff, 3'h0, 1'b0, 4'h3);
        want(32'h0000_000f, 1'b1, 4'h1, 4'hf);
        op(lsb_pkg::xor_op, SL, 32'hdead_beef, 32'hdead_beef, 32'h0, 3'h0, 1'b0, 4'h3);
        want(32'h0, 1'b1, 4'h5, 4'hf);
        op(lsb_pkg::not_op, SB, 32'h0000_00ff, 32'h0, 32'h0, 3'h0, 1'b0, 4'h3);
        want(32'h0, 1'b1, 4'h5, 4'hf);
        op(lsb_pkg::not_op, SW, 32'h0000_0f0f, 32'h0, 32'h0, 3'h0, 1'b0, 4'h3);
        want(32'h0000_f0f0, 1'b1, 4'h9, 4'hf);
        fin("logic");
    endtask

    task automatic t_shift();
        op(lsb_pkg::arith_right_shift_op, SB, 32'h81, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0000_00c0, 1'b1, 4'h9, 4'hf);
        op(lsb_pkg::arith_right_shift_op, SL, 32'h8000_0000, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'hc000_0000, 1'b1, 4'h8, 4'hf);
        op(lsb_pkg::arith_left_shift_op, SW, 32'h4000, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0000_8000, 1'b1, 4'ha, 4'hf);
        op(lsb_pkg::logic_right_shift_op, SB, 32'h81, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0000_0040, 1'b1, 4'h1, 4'hf);
        op(lsb_pkg::logic_left_shift_op, SL, 32'h8000_0001, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0000_0002, 1'b1, 4'h1, 4'hf);
        op(lsb_pkg::rotate_left_op, SB, 32'h81, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0000_0003, 1'b1, 4'h0, 4'hc);
        op(lsb_pkg::rotate_right_op, SW, 32'h0001, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0000_8000, 1'b1, 4'h8, 4'hc);
        op(lsb_pkg::carry_rotate_left_op, SB, 32'h80, 32'h0, 32'h0, 3'h0, 1'b0, 4'h0);
        want(32'h0, 1'b1, 4'h5, 4'hd);
        op(lsb_pkg::carry_rotate_right_op, SL, 32'h2, 32'h0, 32'h0, 3'h0, 1'b0, 4'h1);
        want(32'h8000_0001, 1'b1, 4'h8, 4'hd);
        fin("shift");
    endtask

    task automatic t_bits();
        op(lsb_pkg::bit_force_one_op, SB, 32'h00, 32'h0, 32'h0, 3'h7, 1'b0, 4'ha);
        want(32'h0000_0080, 1'b1, 4'ha, 4'hf);
        op(lsb_pkg::bit_force_one_op, SB, 32'h00, 32'hfd, 32'h0, 3'h0, 1'b1, 4'ha);
        want(32'h0000_0020, 1'b1, 4'ha, 4'hf);
        op(lsb_pkg::bit_force_zero_op, SB, 32'hff, 32'h0, 32'h0, 3'h0, 1'b0, 4'ha);
        want(32'h0000_00fe, 1'b1, 4'ha, 4'hf);
        op(lsb_pkg::bit_flip_op, SB, 32'h0f, 32'h0b, 32'h0, 3'h0, 1'b1, 4'ha);
        want(32'h0000_0007, 1'b1, 4'ha, 4'hf);
        op(lsb_pkg::bit_flip_op, SB, 32'h0f, 32'h0, 32'h0, 3'h7, 1'b0, 4'ha);
        want(32'h0000_008f, 1'b1, 4'ha, 4'hf);
        op(lsb_pkg::bit_probe_op, SB, 32'h10, 32'h0, 32'h0, 3'h4, 1'b0, 4'hf);
        want(32'h0, 1'b0, 4'hb, 4'hf);
        op(lsb_pkg::bit_probe_op, SB, 32'h10, 32'h3, 32'h0, 3'h0, 1'b1, 4'h0);
        want(32'h0, 1'b0, 4'h4, 4'hf);
        fin("bits");
    endtask

    task automatic t_carry();
        op(lsb_pkg::carry_bit_and_op, SB, 32'h02, 32'h0, 32'h0, 3'h1, 1'b0, 4'hf);
        want(32'h0, 1'b0, 4'hf, 4'hf);
        op(lsb_pkg::carry_bit_and_op, SB, 32'h02, 32'h0, 32'h0, 3'h0, 1'b0, 4'hf);
        want(32'h0, 1'b0, 4'he, 4'hf);
        op(lsb_pkg::carry_bit_and_op, SB, 32'h02, 32'h1, 32'h0, 3'h0, 1'b1, 4'hf);
        want(32'h0, 1'b0, 4'hf, 4'hf);
        op(lsb_pkg::carry_inv_bit_and_op, SB, 32'h00, 32'h0, 32'h0, 3'h5, 1'b0, 4'hf);
        want(32'h0, 1'b0, 4'hf, 4'hf);
        op(lsb_pkg::carry_inv_bit_and_op, SB, 32'h20, 32'h0, 32'h0, 3'h5, 1'b0, 4'hf);
        want(32'h0, 1'b0, 4'he, 4'hf);
        op(lsb_pkg::carry_inv_bit_and_op, SB, 32'h20, 32'h5, 32'h0, 3'h5, 1'b1, 4'hf);
        bad();
        op(lsb_pkg::carry_bit_or_op, SB, 32'h40, 32'h0, 32'h0, 3'h6, 1'b0, 4'he);
        want(32'h0, 1'b0, 4'hf, 4'hf);
        op(lsb_pkg::carry_inv_bit_or_op, SB, 32'h40, 32'h0, 32'h0, 3'h6, 1'b0, 4'he);
        want(32'h0, 1'b0, 4'he, 4'hf);
        op(lsb_pkg::carry_inv_bit_or_op, SB, 32'h00, 32'h0, 32'h0, 3'h6, 1'b0, 4'he);
        want(32'h0, 1'b0, 4'hf, 4'hf);
        op(lsb_pkg::carry_inv_bit_or_op, SB, 32'h00, 32'h6, 32'h0, 3'h6, 1'b1, 4'he);
        bad();
        fin("carry");
    endtask

    // ****************************************************************
    // Clock, watchdog and main sequence
    // ****************************************************************
    // Free running 100 ns clock
    initial
    begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    // Tests need about 60 cycles; allow far more
    initial
    begin
        #200000;
        n_fail++;
        summarize();
    end

    // Reset then every scenario back to back
    initial
    begin
        n_fail = 0;
        compares = 0;
        i_rst = 1'b1;
        i_valid = 1'b0;
        i_op = lsb_pkg::compare_op;
        i_size = SB;
        i_dest = 32'h0;
        i_source = 32'h0;
        i_imm = 32'h0;
        i_use_imm = 1'b0;
        i_bit_imm = 3'h0;
        i_bit_by_reg = 1'b0;
        i_flags = 4'h0;
        repeat (5) @(posedge i_clock);
        @(negedge i_clock);
        compares++;
        if (o_done !== 1'b0 || o_write !== 1'b0 || o_illegal !== 1'b0 || o_result !== lsb_pkg::RESULT_RESET
            || o_flags !== lsb_pkg::FLAGS_RESET)
        begin
            n_fail++;
            $display("[ERR] %0t outputs not cleared in reset", $time);
        end
        i_rst = 1'b0;
        t_compare();
        t_negate();
        t_widen();
        t_logic();
        t_shift();
        t_bits();
        t_carry();
        summarize();
    end

endmodule
